// ---- hdl/dppc_params.svh ----
`ifndef DPPC_PARAMS_SVH
`define DPPC_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DPPC_OFF_CTRL      4'h0
`define DPPC_OFF_STAT      4'h4
`define DPPC_OFF_EVT       4'h8
`define DPPC_OFF_MASK      4'hC

// ----------------------------------------
// field positions
// ----------------------------------------
`define DPPC_CTRL_EN_LSB   0
`define DPPC_CTRL_GANG_BIT 8
`define DPPC_STAT_OC_LSB   0
`define DPPC_STAT_VBUS_BIT 8
`define DPPC_STAT_PWR_LSB  16
`define DPPC_STAT_GPWR_BIT 24
`define DPPC_EVT_OC_LSB    0
`define DPPC_EVT_VRISE_BIT 8
`define DPPC_EVT_VFALL_BIT 9
`define DPPC_EVT_WIDTH     10

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define DPPC_CTRL_RST      32'h0000_0000
`define DPPC_MASK_RST      10'h000
`define DPPC_SETTLE_CYC    3

`endif

// ---- hdl/dppc_pkg.sv ----
package dppc_pkg;

	typedef logic [3:0]  dppc_addr_t;
	typedef logic [31:0] dppc_word_t;

	// pin drive modes of a power/sense pin
	typedef enum logic [1:0] {
		DPPC_PIN_HIZ_PD,
		DPPC_PIN_PULLUP,
		DPPC_PIN_DRIVE_LOW
	} dppc_pin_mode_e;

	// {oe_n, pull-up, pull-down}
	typedef logic [2:0] dppc_pin_ctl_t;

	function automatic dppc_pin_ctl_t dppc_pin_ctl(input dppc_pin_mode_e m);
		dppc_pin_ctl_t c;
		c = 3'h4;
		case (m)
			DPPC_PIN_HIZ_PD:    c = 3'h5;
			DPPC_PIN_PULLUP:    c = 3'h6;
			DPPC_PIN_DRIVE_LOW: c = 3'h0;
			default:            c = 3'h5;
		endcase
		return c;
	endfunction

endpackage

// ---- hdl/dppc_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// raw pin levels to synchronised levels
// ----------------------------------------
interface dppc_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport unit (input raw, output sync);
	modport user (output raw, input sync);
endinterface

// ----------------------------------------
// sticky events, mask and interrupt
// ----------------------------------------
interface dppc_evt_if #(parameter int W = 1);
	logic [W-1:0] evt;
	logic         clr;
	logic         mask_we;
	logic [W-1:0] mask_wdata;
	logic [W-1:0] status;
	logic [W-1:0] mask;
	logic         irq;
	modport unit (input evt, clr, mask_we, mask_wdata, output status, mask, irq);
	modport user (output evt, clr, mask_we, mask_wdata, input status, mask, irq);
endinterface

`default_nettype wire

// ---- hdl/dppc_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// two-stage synchroniser
// ----------------------------------------
module dppc_sync #(
	parameter int W = 1
) (
	input  wire logic  ref_clk,
	input  wire logic  sys_rst,
	dppc_sync_if.unit  port
);
	import dppc_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} dppc_sync_s;

	dppc_sync_s s_q;
	dppc_sync_s s_d;

	// first stage feeds only the second
	always_comb begin
		s_d      = s_q;
		s_d.meta = port.raw;
		s_d.stab = s_q.meta;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign port.sync = s_q.stab;

endmodule

`default_nettype wire

// ---- hdl/dppc_evt.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dppc_params.svh"

// ----------------------------------------
// sticky event status with mask
// ----------------------------------------
module dppc_evt #(
	parameter int W = 1
) (
	input  wire logic  ref_clk,
	input  wire logic  sys_rst,
	dppc_evt_if.unit   port
);
	import dppc_pkg::*;

	typedef struct packed {
		logic [W-1:0] status;
		logic [W-1:0] mask;
		logic         irq;
	} dppc_evt_s;

	dppc_evt_s s_q;
	dppc_evt_s s_d;

	// set wins over read clear
	always_comb begin
		s_d = s_q;
		if (port.clr) begin
			s_d.status = '0;
		end
		s_d.status = s_d.status | port.evt;
		if (port.mask_we) begin
			s_d.mask = port.mask_wdata;
		end
		s_d.irq = |(s_d.status & s_d.mask);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_q      <= '0;
			s_q.mask <= W'(`DPPC_MASK_RST);
		end else begin
			s_q <= s_d;
		end
	end

	assign port.status = s_q.status;
	assign port.mask   = s_q.mask;
	assign port.irq    = s_q.irq;

endmodule

`default_nettype wire

// ---- hdl/dppc_top.sv ----
// Functional notes
// - an enabled port has its power/sense pin released as an input with the pull-up on; in ganged mode the code leaves that pin undriven with the pull-down.
// - while a port is enabled, a low level on its pin is that port's overcurrent report; in ganged mode the code ignores that pin and senses the shared pin.
// - a port disabled by configuration or by host request has its pin driven low; in ganged mode the code leaves that pin undriven with the pull-down.
// - six independent power/sense pins, one per downstream port.
// - the upstream power detect input tells whether upstream bus power is present.
// - toggling upstream power detect re-runs attachment without a full reset.
// - signals named with a low-active suffix are asserted low, all others high.
// - in ganged mode the shared pin enables power and senses overcurrent for all ports.
// - during reset the pins are undriven with the pull-down applied.
`timescale 1ns/1ns
`default_nettype none
`include "dppc_params.svh"

module dppc_top #(
	parameter int NPORT = 6
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	// ----------------------------------------
	// register port
	// ----------------------------------------
	input  wire dppc_pkg::dppc_addr_t reg_addr,
	input  wire dppc_pkg::dppc_word_t reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output var  dppc_pkg::dppc_word_t reg_rdata,
	output var  logic                 irq,
	// ----------------------------------------
	// hub core side
	// ----------------------------------------
	input  wire logic [NPORT-1:0]     host_port_dis,
	output var  logic [NPORT-1:0]     port_oc_flag,
	output var  logic [NPORT-1:0]     port_power_on,
	output var  logic                 upstream_power_present,
	output var  logic                 upstream_attach_req,
	output var  logic                 upstream_detach_req,
	// ----------------------------------------
	// per-port power/sense pins
	// ----------------------------------------
	input  wire logic [NPORT-1:0]     port_power_sense_pin_in,
	output var  logic [NPORT-1:0]     port_power_sense_pin_out,
	output var  logic [NPORT-1:0]     port_power_sense_pin_oe_n,
	output var  logic [NPORT-1:0]     port_power_sense_pin_pu,
	output var  logic [NPORT-1:0]     port_power_sense_pin_pd,
	// ----------------------------------------
	// shared (ganged) power/sense pin
	// ----------------------------------------
	input  wire logic                 shared_power_sense_pin_in,
	output var  logic                 shared_power_sense_pin_out,
	output var  logic                 shared_power_sense_pin_oe_n,
	output var  logic                 shared_power_sense_pin_pu,
	output var  logic                 shared_power_sense_pin_pd,
	// ----------------------------------------
	// upstream bus power detect
	// ----------------------------------------
	input  wire logic                 upstream_power_detect
);
	import dppc_pkg::*;

	localparam int EW = `DPPC_EVT_WIDTH;
	localparam int SW = NPORT + 2;
	localparam int ST = `DPPC_SETTLE_CYC;

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// strobe at one register offset
	function automatic logic reg_hit(
		input logic       strobe,
		input dppc_addr_t addr,
		input dppc_addr_t offs
	);
		return strobe && (addr == offs);
	endfunction

	// rise of a level against its last value
	function automatic logic rise(
		input logic now,
		input logic was
	);
		return now & ~was;
	endfunction

	// released long enough for the pull-up
	function automatic logic settled(
		input logic [ST-1:0] hist
	);
		return &hist;
	endfunction

	// low pin on a settled released port
	function automatic logic oc_sense(
		input logic on,
		input logic done,
		input logic pin
	);
		return on & done & ~pin;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [NPORT-1:0]        cfg_en;
		logic                    gang;
		logic [NPORT-1:0][ST-1:0] hist;
		logic [ST-1:0]           ghist;
		logic [NPORT-1:0]        oc_lvl;
		logic                    vbus;
		logic                    attach;
		logic                    detach;
		logic [NPORT-1:0]        pin_oe_n;
		logic [NPORT-1:0]        pin_pu;
		logic [NPORT-1:0]        pin_pd;
		logic [NPORT-1:0]        pin_out;
		logic                    sh_oe_n;
		logic                    sh_pu;
		logic                    sh_pd;
		logic                    sh_out;
		logic [NPORT-1:0]        pwr;
		logic                    irq;
		dppc_word_t              rdata;
	} dppc_top_s;

	dppc_top_s s_q;
	dppc_top_s s_d;

	// ----------------------------------------
	// synchronisers and event unit
	// ----------------------------------------
	dppc_sync_if #(.W(SW)) sync_if ();
	dppc_evt_if  #(.W(EW)) evt_if ();

	assign sync_if.raw = {upstream_power_detect, shared_power_sense_pin_in,
		port_power_sense_pin_in};

	dppc_sync #(
		.W (SW)
	) u_sync (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.port    (sync_if)
	);

	dppc_evt #(
		.W (EW)
	) u_evt (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.port    (evt_if)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [NPORT-1:0] pin_s;
	logic             sh_s;
	logic             vbus_s;
	logic [NPORT-1:0] req_on;
	logic             any_on;
	logic [NPORT-1:0] port_on;
	logic             sh_on;
	logic [NPORT-1:0] oc_now;
	logic             rd_evt;

	assign pin_s  = sync_if.sync[NPORT-1:0];
	assign sh_s   = sync_if.sync[NPORT];
	assign vbus_s = sync_if.sync[NPORT+1];

	assign req_on  = s_q.cfg_en & ~host_port_dis;
	assign any_on  = |req_on;
	assign port_on = s_q.gang ? '0 : req_on;
	assign sh_on   = s_q.gang & any_on;
	assign rd_evt  = reg_hit(reg_rd, reg_addr, `DPPC_OFF_EVT);

	// ----------------------------------------
	// event wiring
	// ----------------------------------------
	always_comb begin
		evt_if.evt = '0;
		evt_if.evt[`DPPC_EVT_OC_LSB +: NPORT] = oc_now & ~s_q.oc_lvl;
		evt_if.evt[`DPPC_EVT_VRISE_BIT] = rise(vbus_s, s_q.vbus);
		evt_if.evt[`DPPC_EVT_VFALL_BIT] = rise(s_q.vbus, vbus_s);
	end

	// read of the event register clears it
	assign evt_if.clr        = rd_evt;
	assign evt_if.mask_we    = reg_hit(reg_wr, reg_addr, `DPPC_OFF_MASK);
	assign evt_if.mask_wdata = reg_wdata[EW-1:0];

	// ----------------------------------------
	// overcurrent sensing
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			// low pin while enabled and settled
			oc_now[i] = oc_sense(port_on[i], settled(s_q.hist[i]), pin_s[i]);
			if (oc_sense(sh_on, settled(s_q.ghist), sh_s)) begin
				oc_now[i] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		dppc_pin_ctl_t c;
		dppc_word_t    w;
		c   = '0;
		w   = '0;
		s_d = s_q;

		// register writes
		if (reg_hit(reg_wr, reg_addr, `DPPC_OFF_CTRL)) begin
			s_d.cfg_en = reg_wdata[`DPPC_CTRL_EN_LSB +: NPORT];
			s_d.gang   = reg_wdata[`DPPC_CTRL_GANG_BIT];
		end

		// settle history masks the pull-up rise time
		for (int i = 0; i < NPORT; i++) begin
			s_d.hist[i] = {s_q.hist[i][ST-2:0], port_on[i]};
		end
		s_d.ghist = {s_q.ghist[ST-2:0], sh_on};

		s_d.oc_lvl = oc_now;

		s_d.vbus   = vbus_s;
		s_d.attach = rise(vbus_s, s_q.vbus);
		s_d.detach = rise(s_q.vbus, vbus_s);

		// per-port pin drive
		for (int i = 0; i < NPORT; i++) begin
			if (s_q.gang) begin
				c = dppc_pin_ctl(DPPC_PIN_HIZ_PD);
			end else if (req_on[i]) begin
				c = dppc_pin_ctl(DPPC_PIN_PULLUP);
			end else begin
				c = dppc_pin_ctl(DPPC_PIN_DRIVE_LOW);
			end
			s_d.pin_oe_n[i] = c[2];
			s_d.pin_pu[i]   = c[1];
			s_d.pin_pd[i]   = c[0];
			s_d.pin_out[i]  = 1'b0;
		end

		// shared pin drive
		if (!s_q.gang) begin
			c = dppc_pin_ctl(DPPC_PIN_HIZ_PD);
		end else if (any_on) begin
			c = dppc_pin_ctl(DPPC_PIN_PULLUP);
		end else begin
			c = dppc_pin_ctl(DPPC_PIN_DRIVE_LOW);
		end
		s_d.sh_oe_n = c[2];
		s_d.sh_pu   = c[1];
		s_d.sh_pd   = c[0];
		s_d.sh_out  = 1'b0;

		s_d.pwr = s_q.gang ? (any_on ? req_on : '0) : req_on;
		s_d.irq = evt_if.irq;

		// register reads, data in the next cycle
		if (reg_rd) begin
			case (reg_addr)
				`DPPC_OFF_CTRL: begin
					w[`DPPC_CTRL_EN_LSB +: NPORT] = s_q.cfg_en;
					w[`DPPC_CTRL_GANG_BIT]        = s_q.gang;
				end
				`DPPC_OFF_STAT: begin
					w[`DPPC_STAT_OC_LSB +: NPORT]  = s_q.oc_lvl;
					w[`DPPC_STAT_VBUS_BIT]         = s_q.vbus;
					w[`DPPC_STAT_PWR_LSB +: NPORT] = s_q.pwr;
					w[`DPPC_STAT_GPWR_BIT]         = sh_on;
				end
				`DPPC_OFF_EVT: begin
					w[EW-1:0] = evt_if.status;
				end
				`DPPC_OFF_MASK: begin
					w[EW-1:0] = evt_if.mask;
				end
				default: begin
					w = '0;
				end
			endcase
		end
		s_d.rdata = w;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_q          <= '0;
			s_q.cfg_en   <= NPORT'(`DPPC_CTRL_RST);
			s_q.pin_oe_n <= '1;
			s_q.pin_pd   <= '1;
			s_q.sh_oe_n  <= 1'b1;
			s_q.sh_pd    <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata                   = s_q.rdata;
	assign irq                         = s_q.irq;
	assign port_oc_flag                = s_q.oc_lvl;
	assign port_power_on               = s_q.pwr;
	assign upstream_power_present      = s_q.vbus;
	assign upstream_attach_req         = s_q.attach;
	assign upstream_detach_req         = s_q.detach;
	assign port_power_sense_pin_out    = s_q.pin_out;
	assign port_power_sense_pin_oe_n   = s_q.pin_oe_n;
	assign port_power_sense_pin_pu     = s_q.pin_pu;
	assign port_power_sense_pin_pd     = s_q.pin_pd;
	assign shared_power_sense_pin_out  = s_q.sh_out;
	assign shared_power_sense_pin_oe_n = s_q.sh_oe_n;
	assign shared_power_sense_pin_pu   = s_q.sh_pu;
	assign shared_power_sense_pin_pd   = s_q.sh_pd;

endmodule

`default_nettype wire

// ---- sim/dppc_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

module dppc_chk #(
	parameter int NPORT = 6
) (
	input wire logic             ref_clk,
	input wire logic             sys_rst,
	input wire logic [NPORT-1:0] host_port_dis,
	input wire logic [NPORT-1:0] port_oc_flag,
	input wire logic [NPORT-1:0] port_power_on,
	input wire logic             upstream_power_present,
	input wire logic             upstream_attach_req,
	input wire logic             upstream_detach_req,
	input wire logic             upstream_power_detect,
	input wire logic [NPORT-1:0] port_power_sense_pin_out,
	input wire logic [NPORT-1:0] port_power_sense_pin_oe_n,
	input wire logic [NPORT-1:0] port_power_sense_pin_pu,
	input wire logic [NPORT-1:0] port_power_sense_pin_pd,
	input wire logic             shared_power_sense_pin_oe_n,
	input wire logic             shared_power_sense_pin_pu,
	input wire logic             shared_power_sense_pin_pd
);
	// ----
	// pin and status checks
	// ----
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	a_rst_pins_off: assert property (disable iff (1'b0) sys_rst |=>
		&port_power_sense_pin_oe_n && &port_power_sense_pin_pd && port_power_sense_pin_pu == '0
		&& shared_power_sense_pin_oe_n && shared_power_sense_pin_pd) else $error("pins active in reset");
	a_drive_no_pull: assert property (((~port_power_sense_pin_oe_n
		& (port_power_sense_pin_pu | port_power_sense_pin_pd)) == '0)
		&& port_power_sense_pin_out == '0) else $error("driven pin has a pull");
	a_pullup_power: assert property ((port_power_sense_pin_pu
		& ~(port_power_on & port_power_sense_pin_oe_n)) == '0) else $error("pull-up without power");
	a_host_dis_off: assert property ((port_power_on
		& $past(host_port_dis)) == '0) else $error("host-disabled port powered");
	a_oc_needs_on: assert property ((port_oc_flag & ~$past(port_oc_flag)
		& ~$past(port_power_on)) == '0) else $error("overcurrent on unpowered port");
	a_attach_pulse: assert property (upstream_attach_req |->
		upstream_power_present ##1 !upstream_attach_req) else $error("bad attach pulse");
	a_detach_pulse: assert property ($fell(upstream_power_present) |->
		upstream_detach_req) else $error("missing detach pulse");
	a_vbus_follow: assert property (upstream_power_detect [*4] |->
		upstream_power_present) else $error("power present late");
	a_vbus_drop: assert property (!upstream_power_detect [*4] |->
		!upstream_power_present) else $error("power absent late");
	a_gang_pins: assert property (shared_power_sense_pin_pu |-> &port_power_sense_pin_oe_n
		&& &port_power_sense_pin_pd) else $error("port pins active in gang mode");

	c_oc_seen: cover property ($rose(|port_oc_flag));
	c_attach: cover property (upstream_attach_req);
	c_gang_on: cover property (shared_power_sense_pin_pu);
endmodule

`default_nettype wire

// ---- sim/dppc_switch_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module dppc_switch_model #(
	parameter int W = 6
) (
	input  wire logic         ref_clk,
	input  wire logic [W-1:0] oe_n,
	input  wire logic [W-1:0] out,
	input  wire logic [W-1:0] pu,
	input  wire logic [W-1:0] pd,
	input  wire logic [W-1:0] oc_pull,
	output var  logic [W-1:0] lvl
);
	// ----
	// switch and current monitor line
	// ----
	logic [W-1:0] flip_q = '0;

	always @(posedge ref_clk) begin
		flip_q <= ~flip_q;
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			lvl[i] = !oe_n[i] ? out[i] : oc_pull[i] ? 1'b0 : pu[i] ? 1'b1 : pd[i] ? 1'b0 : flip_q[i];
		end
	end
endmodule

`default_nettype wire

// ---- sim/downstream_port_power_control_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h", $time, a); end end

module downstream_port_power_control_tb;
	import dppc_pkg::*;
	localparam int NPORT = 6;
	logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq, rd_q = 1'b0;
	dppc_addr_t reg_addr = '0;
	dppc_word_t reg_wdata = '0, reg_rdata, e, m;
	logic [5:0] host_port_dis = '0, mon_oc = '0, en, hd;
	logic [5:0] port_oc_flag, port_power_on, pin_out, pin_oe_n, pin_pu, pin_pd;
	wire logic [5:0] pin_in;
	wire logic sh_in;
	logic sh_out, sh_oe_n, sh_pu, sh_pd, mon_sh_oc = 1'b0, upstream_power_detect = 1'b0;
	logic upstream_power_present, upstream_attach_req, upstream_detach_req;
	integer seed = 91;
	int checks = 0, failures = 0, cycles = 0;
	dppc_word_t exp_q[$], msk_q[$];

	always #25 ref_clk = ~ref_clk;

	dppc_top #(.NPORT(NPORT)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.host_port_dis(host_port_dis), .port_oc_flag(port_oc_flag), .port_power_on(port_power_on),
		.upstream_power_present(upstream_power_present), .upstream_attach_req(upstream_attach_req),
		.upstream_detach_req(upstream_detach_req), .port_power_sense_pin_in(pin_in),
		.port_power_sense_pin_out(pin_out), .port_power_sense_pin_oe_n(pin_oe_n),
		.port_power_sense_pin_pu(pin_pu), .port_power_sense_pin_pd(pin_pd),
		.shared_power_sense_pin_in(sh_in), .shared_power_sense_pin_out(sh_out),
		.shared_power_sense_pin_oe_n(sh_oe_n), .shared_power_sense_pin_pu(sh_pu),
		.shared_power_sense_pin_pd(sh_pd), .upstream_power_detect(upstream_power_detect));

	dppc_switch_model #(.W(6)) i_ports (.ref_clk(ref_clk), .oe_n(pin_oe_n), .out(pin_out),
		.pu(pin_pu), .pd(pin_pd), .oc_pull(mon_oc), .lvl(pin_in));
	dppc_switch_model #(.W(1)) i_shared (.ref_clk(ref_clk), .oe_n(sh_oe_n), .out(sh_out),
		.pu(sh_pu), .pd(sh_pd), .oc_pull(mon_sh_oc), .lvl(sh_in));

	// ----
	// bus tasks and read monitor
	// ----
	task automatic wr(input dppc_addr_t a, input dppc_word_t d);
		@(posedge ref_clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input dppc_addr_t a, input dppc_word_t x, input dppc_word_t k);
		@(posedge ref_clk);
		exp_q.push_back(x & k); msk_q.push_back(k);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		rd_q <= reg_rd;
		if (rd_q) begin
			e = exp_q.pop_front(); m = msk_q.pop_front();
			`CHK(reg_rdata & m, e)
		end
		cycles++;
		if (cycles == 3000) begin
			failures++; end_sim;
		end
	end

	// ----
	// scenarios
	// ----
	initial begin
		idle(6); sys_rst <= 1'b0;
		wr(4'h2, 32'hFFFF_FFFF);
		rd(4'h2, 32'h0, 32'hFFFF_FFFF);
		rd(4'h0, 32'h0, 32'hFFFF_FFFF);
		rd(4'h4, 32'h0, 32'hFFFF_FFFF);
		for (int i = 0; i < 6; i++) begin
			en = 6'($random(seed)); hd = 6'($random(seed));
			host_port_dis <= hd;
			wr(4'h0, dppc_word_t'(en));
			idle(6);
			rd(4'h4, dppc_word_t'(en & ~hd) << 16, 32'h003F_013F);
		end
		host_port_dis <= '0;
		wr(4'h0, 32'h3F); idle(6);
		rd(4'h8, 32'h0, 32'h3FF);
		for (int k = 0; k < 6; k++) begin
			wr(4'hC, (k % 2) ? 32'h0 : 32'h3F);
			mon_oc <= 6'(1 << k); idle(8);
			`CHK(irq, (k % 2) == 0)
			rd(4'h4, 32'h003F_0000 | (1 << k), 32'h003F_013F);
			rd(4'h8, 32'(1 << k), 32'h3FF);
			mon_oc <= '0; idle(8);
			rd(4'h4, 32'h003F_0000, 32'h003F_013F);
			`CHK(irq, 1'b0)
		end
		wr(4'hC, 32'h300); upstream_power_detect <= 1'b1; idle(6);
		`CHK(irq, 1'b1)
		rd(4'h4, 32'h003F_0100, 32'h003F_0100);
		rd(4'h8, 32'h100, 32'h3FF);
		upstream_power_detect <= 1'b0; idle(6);
		rd(4'h8, 32'h200, 32'h3FF);
		rd(4'h4, 32'h003F_0000, 32'h003F_0100);
		wr(4'h0, 32'h13F); idle(6);
		rd(4'h4, 32'h0100_0000, 32'h0100_0000);
		mon_sh_oc <= 1'b1; idle(8);
		rd(4'h4, 32'h3F, 32'h3F);
		mon_sh_oc <= 1'b0;
		wr(4'h0, 32'h100); idle(6);
		rd(4'h4, 32'h0, 32'h0100_003F);
		sys_rst <= 1'b1; idle(3); sys_rst <= 1'b0;
		rd(4'h0, 32'h0, 32'hFFFF_FFFF);
		rd(4'hC, 32'h0, 32'hFFFF_FFFF);
		idle(4);
		end_sim;
	end
endmodule

bind dppc_top dppc_chk #(.NPORT(NPORT)) i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.host_port_dis(host_port_dis), .port_oc_flag(port_oc_flag), .port_power_on(port_power_on),
	.upstream_power_present(upstream_power_present), .upstream_attach_req(upstream_attach_req),
	.upstream_detach_req(upstream_detach_req), .upstream_power_detect(upstream_power_detect),
	.port_power_sense_pin_out(port_power_sense_pin_out),
	.port_power_sense_pin_oe_n(port_power_sense_pin_oe_n),
	.port_power_sense_pin_pu(port_power_sense_pin_pu),
	.port_power_sense_pin_pd(port_power_sense_pin_pd),
	.shared_power_sense_pin_oe_n(shared_power_sense_pin_oe_n),
	.shared_power_sense_pin_pu(shared_power_sense_pin_pu),
	.shared_power_sense_pin_pd(shared_power_sense_pin_pd));

`default_nettype wire
